// File: hw/psia_regs.sv
`timescale 1ns/1ps
`include "psia_defs.svh"

// Overview of operation
// - A manual master/slave fault latches status bit 15 until it is read.
// - Status bit 14 shows the master/slave outcome, one for master.
// - Status bits 13 and 12 show local and remote receiver health.
// - Status bits 11 and 10 show partner gigabit full and half duplex.
// - Reserved fields ignore writes and read back as zero.
// - Status bits 7:0 count idle errors, cleared by a read and by reset.
// - Extended registers are reached only through offsets 0xd and 0xe.
// - Function 00 makes a data-port write load the extended pointer.
// - Function 01 accesses the pointed register and keeps the pointer.
// - Function 10 advances the pointer after every read or write.
// - Function 11 advances the pointer after writes only.
// - Port accesses count only when the device select is all ones.
// - The port is the pointer in function 00, else the data window.
// - The ability register reads a fixed 16'h3000.
module psia_regs #(
  parameter int EXT_AW = 8
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [4:0]         mgmt_addr,
  input  wire logic               mgmt_wr,
  input  wire logic               mgmt_rd,
  input  wire psia_pkg::psia_word_t mgmt_wdata,
  output psia_pkg::psia_word_t    mgmt_rdata,
  output logic                    mgmt_rvalid,
  input  wire logic               ms_fault_evt,
  input  wire logic               ms_resolved_master,
  input  wire logic               local_rx_ok,
  input  wire logic               remote_rx_ok,
  input  wire logic               lp_1000_fd,
  input  wire logic               lp_1000_hd,
  input  wire logic               idle_err_evt
);
  import psia_pkg::*;

  // ============================================================
  // State
  logic        fault_latch;
  logic [7:0]  idle_cnt;
  psia_func_t  ind_func;
  logic [4:0]  ind_dev;
  psia_word_t  ind_ptr;
  logic        rd_pend;
  logic        rd_use_mem;
  psia_word_t  rd_direct;
  logic [4:0]  rd_addr;
  logic [4:0]  rsp_addr;

  logic        next_fault;
  logic [7:0]  next_cnt;
  psia_word_t  next_ptr;

  // ============================================================
  // Extended register store
  psia_ext_if #(.AW(EXT_AW)) ext (.ref_clk(ref_clk));

  psia_ext_mem #(
    .AW (EXT_AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bus     (ext)
  );

  // ============================================================
  // Address decode
  wire sel_sts  = (mgmt_addr == `PSIA_OFS_LINK_STS);
  wire sel_ctrl = (mgmt_addr == `PSIA_OFS_IND_CTRL);
  wire sel_data = (mgmt_addr == `PSIA_OFS_IND_DATA);
  wire sel_abil = (mgmt_addr == `PSIA_OFS_ABILITY);

  wire dev_ok    = (ind_dev == `PSIA_TARGET_DEVICE_SELECT_OWN);
  wire port_wr   = mgmt_wr && sel_data && dev_ok;
  wire port_rd   = mgmt_rd && sel_data && dev_ok;

  wire addr_mode = (ind_func == PSIA_FN_ADDR);
  wire ptr_load  = port_wr && addr_mode;
  wire data_wr   = port_wr && !addr_mode;
  wire data_rd   = port_rd && !addr_mode;

  wire inc_on_wr = (ind_func == PSIA_FN_INC_RW) ||
                   (ind_func == PSIA_FN_INC_WR);
  wire inc_on_rd = (ind_func == PSIA_FN_INC_RW);
  wire ptr_inc   = (data_wr && inc_on_wr) || (data_rd && inc_on_rd);

  wire ctrl_wr   = mgmt_wr && sel_ctrl;
  wire sts_rd    = mgmt_rd && sel_sts;
  wire cnt_sat   = (idle_cnt == `PSIA_CNT_MAX);

  // ============================================================
  // Read values of the direct registers
  // Resolution bit, receiver health, partner
  wire [15:0] sts_word  = {fault_latch, ms_resolved_master, local_rx_ok,
                           remote_rx_ok, lp_1000_fd, lp_1000_hd,
                           2'b00, idle_cnt};
  // Reserved control bits are tied to zero
  wire [15:0] ctrl_word = {ind_func, 9'h000, ind_dev};
  // Port reads in pointer mode show the pointer; gated reads give zero
  wire [15:0] port_word = (dev_ok && addr_mode) ? ind_ptr
                                                 : `PSIA_WORD_ZERO;
  wire [15:0] abil_word = `PSIA_ABILITY_VAL;

  // Unmapped offsets read as zero
  wire [15:0] direct_val = sel_sts  ? sts_word  :
                           sel_ctrl ? ctrl_word :
                           sel_data ? port_word :
                           sel_abil ? abil_word : `PSIA_WORD_ZERO;

  // ============================================================
  // Store connection, the pointer addresses the window directly
  // Only the port reaches the extended set
  assign ext.wr_en = data_wr;
  assign ext.rd_en = data_rd;
  assign ext.addr  = ind_ptr[EXT_AW-1:0];
  assign ext.wdata = mgmt_wdata;

  // ============================================================
  // Next state of the latched fault and the idle counter
  // Latch on fault, clear on read; a new fault wins
  assign next_fault = ms_fault_evt || (fault_latch && !sts_rd);

  // Read clears the count, the same-cycle error still counts
  // Hold at the top value instead of wrapping
  assign next_cnt = sts_rd                      ? {7'h00, idle_err_evt} :
                    (idle_err_evt && !cnt_sat)  ? idle_cnt + 8'h01      :
                                                  idle_cnt;

  // Pointer load, hold when no increment applies
  assign next_ptr = ptr_load ? mgmt_wdata        :
                    ptr_inc  ? ind_ptr + 16'h0001 :
                               ind_ptr;

  // ============================================================
  // Status flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fault_latch <= 1'b0;
      idle_cnt    <= `PSIA_CNT_RST;
    end else begin
      fault_latch <= next_fault;
      idle_cnt    <= next_cnt;
    end
  end

  // Control register; reserved write bits are dropped
  // Reserved bits ignored
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ind_func <= PSIA_FN_ADDR;
      ind_dev  <= `PSIA_DEV_RST;
    end else if (ctrl_wr) begin
      ind_func <= psia_func_t'(mgmt_wdata[`PSIA_CTRL_FN_MSB:
                                          `PSIA_CTRL_FN_LSB]);
      ind_dev  <= mgmt_wdata[`PSIA_CTRL_DEV_MSB:`PSIA_CTRL_DEV_LSB];
    end
  end

  // Extended pointer; advances only after the store used the old value
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ind_ptr <= `PSIA_PTR_RST;
    end else begin
      ind_ptr <= next_ptr;
    end
  end

  // ============================================================
  // Read pipeline: capture at the request edge, answer one edge later.
  // Capturing the status word at the request keeps the value that the
  // clear-on-read is about to wipe.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_pend    <= 1'b0;
      rd_use_mem <= 1'b0;
      rd_direct  <= `PSIA_WORD_ZERO;
    end else begin
      rd_pend    <= mgmt_rd;
      rd_use_mem <= data_rd;
      rd_direct  <= direct_val;
    end
  end

  // Output flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mgmt_rvalid <= 1'b0;
      mgmt_rdata  <= `PSIA_WORD_ZERO;
    end else begin
      mgmt_rvalid <= rd_pend;
      mgmt_rdata  <= rd_use_mem ? ext.rdata : rd_direct;
    end
  end

  // Offset of each answer, two edges behind its request, for the checks
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_addr  <= 5'h00;
      rsp_addr <= 5'h00;
    end else begin
      rd_addr  <= mgmt_addr;
      rsp_addr <= rd_addr;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  wire rsp_sts  = mgmt_rvalid && (rsp_addr == `PSIA_OFS_LINK_STS);
  wire rsp_ctrl = mgmt_rvalid && (rsp_addr == `PSIA_OFS_IND_CTRL);
  wire rsp_abil = mgmt_rvalid && (rsp_addr == `PSIA_OFS_ABILITY);
  wire rsp_other = mgmt_rvalid && !rsp_sts && !rsp_ctrl && !rsp_abil &&
                   (rsp_addr != `PSIA_OFS_IND_DATA);

  fault_set_a : assert property (
    ms_fault_evt |=> fault_latch)
    else $error("fault event not latched");

  fault_clear_a : assert property (
    sts_rd && !ms_fault_evt |=> !fault_latch ##1 mgmt_rvalid)
    else $error("fault latch not cleared by read");

  master_bit_a : assert property (
    rsp_sts |-> mgmt_rdata[`PSIA_STS_MASTER_BIT] ==
                $past(ms_resolved_master, 2))
    else $error("master resolution bit wrong");

  rx_health_a : assert property (
    rsp_sts |-> mgmt_rdata[13:12] ==
                {$past(local_rx_ok, 2), $past(remote_rx_ok, 2)})
    else $error("receiver health bits wrong");

  partner_ability_a : assert property (
    rsp_sts |-> mgmt_rdata[11:10] ==
                {$past(lp_1000_fd, 2), $past(lp_1000_hd, 2)})
    else $error("partner ability bits wrong");

  reserved_zero_a : assert property (
    (rsp_sts  |-> mgmt_rdata[9:8] == 2'b00) and
    (rsp_ctrl |-> mgmt_rdata[13:5] == 9'h000) and
    (rsp_abil |-> mgmt_rdata[11:0] == 12'h000))
    else $error("reserved bits not zero");

  idle_count_a : assert property (
    idle_err_evt && !sts_rd && !cnt_sat |=>
      idle_cnt == $past(idle_cnt) + 8'h01)
    else $error("idle error not counted");

  idle_clear_a : assert property (
    sts_rd |=> idle_cnt == {7'h00, $past(idle_err_evt)}
           ##1 mgmt_rdata[7:0] == $past(idle_cnt, 2))
    else $error("idle count not cleared on read");

  idle_sat_a : assert property (
    cnt_sat && !sts_rd |=> cnt_sat)
    else $error("idle count wrapped");

  ptr_load_a : assert property (
    ptr_load |=> ind_ptr == $past(mgmt_wdata))
    else $error("pointer not loaded");

  ptr_hold_a : assert property (
    (data_rd || data_wr) && ind_func == PSIA_FN_DATA |=> $stable(ind_ptr))
    else $error("pointer moved in no-increment mode");

  ptr_inc_a : assert property (
    (data_rd || data_wr) && ind_func == PSIA_FN_INC_RW |=>
      ind_ptr == $past(ind_ptr) + 16'h0001)
    else $error("pointer not advanced");

  wr_only_a : assert property (
    ind_func == PSIA_FN_INC_WR && data_rd && !mgmt_wr |=> $stable(ind_ptr))
    else $error("pointer advanced on read in write-only mode");

  target_device_select_gate_a : assert property (
    sel_data && !dev_ok && !ctrl_wr |=> $stable(ind_ptr))
    else $error("port access with wrong device select took effect");

  ptr_readback_a : assert property (
    mgmt_rd && sel_data && dev_ok && addr_mode |->
      ##2 mgmt_rvalid && mgmt_rdata == $past(ind_ptr, 2))
    else $error("pointer readback wrong");

  ability_fixed_a : assert property (
    rsp_abil |-> mgmt_rdata == `PSIA_ABILITY_VAL)
    else $error("ability register not fixed");

  // Latched fault in the answer and the set-wins case
  fault_bit_a : assert property (
    rsp_sts |-> mgmt_rdata[`PSIA_STS_FAULT_BIT] == $past(fault_latch, 2))
    else $error("fault bit in answer wrong");

  fault_win_a : assert property (
    sts_rd && ms_fault_evt |=> fault_latch)
    else $error("fault lost when read and event coincide");

  ctrl_readback_a : assert property (
    rsp_ctrl |-> mgmt_rdata[15:14] == $past(ind_func, 2) &&
                 mgmt_rdata[4:0] == $past(ind_dev, 2))
    else $error("control readback wrong");

  wr_inc_a : assert property (
    data_wr && ind_func == PSIA_FN_INC_WR |=>
      ind_ptr == $past(ind_ptr) + 16'h0001)
    else $error("pointer not advanced on write");

  // Device-select gate on the store and on the answer
  store_gate_a : assert property (
    mgmt_wr && sel_data && !dev_ok |-> !ext.wr_en)
    else $error("store written with wrong device select");

  data_gate_a : assert property (
    mgmt_rd && sel_data && !dev_ok |-> ##2 mgmt_rdata == `PSIA_WORD_ZERO)
    else $error("read with wrong device select not zero");

  unmapped_zero_a : assert property (
    rsp_other |-> mgmt_rdata == `PSIA_WORD_ZERO)
    else $error("unmapped offset not zero");

  rsp_timing_a : assert property (
    mgmt_rd |-> ##2 mgmt_rvalid)
    else $error("read answer late");

  rsp_origin_a : assert property (
    mgmt_rvalid |-> $past(mgmt_rd, 2))
    else $error("answer without a read");

  cover_sts_clear  : cover property (sts_rd && fault_latch && idle_cnt != 0);
  cover_inc_read   : cover property (data_rd && ind_func == PSIA_FN_INC_RW);
  cover_wr_only    : cover property (data_wr && ind_func == PSIA_FN_INC_WR);
  cover_saturation : cover property (cnt_sat && idle_err_evt);
  cover_fault_win  : cover property (sts_rd && ms_fault_evt);

endmodule

// File: hw/psia_defs.svh
`ifndef PSIA_DEFS_SVH
`define PSIA_DEFS_SVH

// ============================================================
// Register offsets on the management port
`define PSIA_OFS_LINK_STS  5'h0a
`define PSIA_OFS_IND_CTRL  5'h0d
`define PSIA_OFS_IND_DATA  5'h0e
`define PSIA_OFS_ABILITY   5'h0f

// ============================================================
// Field positions
`define PSIA_STS_FAULT_BIT   15
`define PSIA_STS_MASTER_BIT  14
`define PSIA_STS_LOC_RX_BIT  13
`define PSIA_STS_REM_RX_BIT  12
`define PSIA_STS_LP_FD_BIT   11
`define PSIA_STS_LP_HD_BIT   10
`define PSIA_STS_RSVD_MSB    9
`define PSIA_STS_RSVD_LSB    8
`define PSIA_STS_CNT_MSB     7
`define PSIA_STS_CNT_LSB     0
`define PSIA_CTRL_FN_MSB     15
`define PSIA_CTRL_FN_LSB     14
`define PSIA_CTRL_RSVD_MSB   13
`define PSIA_CTRL_RSVD_LSB   5
`define PSIA_CTRL_DEV_MSB    4
`define PSIA_CTRL_DEV_LSB    0
`define PSIA_ABIL_RSVD_MSB   11
`define PSIA_ABIL_RSVD_LSB   0

// ============================================================
// Values and reset values
`define PSIA_TARGET_DEVICE_SELECT_OWN       5'h1f
`define PSIA_ABILITY_VAL     16'h3000
`define PSIA_PTR_RST         16'h0000
`define PSIA_DEV_RST         5'h00
`define PSIA_CNT_RST         8'h00
`define PSIA_CNT_MAX         8'hff
`define PSIA_WORD_ZERO       16'h0000

`endif

// File: hw/psia_pkg.sv
package psia_pkg;

  // Function field of the indirect access control register
  typedef enum logic [1:0] {
    PSIA_FN_ADDR   = 2'b00,
    PSIA_FN_DATA   = 2'b01,
    PSIA_FN_INC_RW = 2'b10,
    PSIA_FN_INC_WR = 2'b11
  } psia_func_t;

  typedef logic [15:0] psia_word_t;

endpackage

// File: hw/psia_ext_if.sv
`timescale 1ns/1ps

// ============================================================
// Link between the register slice and the extended register store
interface psia_ext_if #(
  parameter int AW = 8
) (
  input wire logic ref_clk
);
  logic          wr_en;
  logic          rd_en;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;

  modport ctrl (output wr_en, output rd_en, output addr, output wdata,
                input rdata);
  modport mem  (input wr_en, input rd_en, input addr, input wdata,
                output rdata);
endinterface

// File: hw/psia_ext_mem.sv
`timescale 1ns/1ps
`include "psia_defs.svh"

// ============================================================
// Extended register store, one-cycle registered read
module psia_ext_mem #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  psia_ext_if.mem  bus
);
  import psia_pkg::*;

  psia_word_t store [0:(1<<AW)-1];
  psia_word_t rdata_q;

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (bus.wr_en) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  // Read data comes straight from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= `PSIA_WORD_ZERO;
    end else if (bus.rd_en) begin
      rdata_q <= store[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;

endmodule

// File: dv/psia_station.sv
`timescale 1ns/1ps

// ============================================================
// Management station model, one request per access
module psia_station (
  input  wire logic                 ref_clk,
  output logic [4:0]                mgmt_addr,
  output logic                      mgmt_wr,
  output logic                      mgmt_rd,
  output psia_pkg::psia_word_t      mgmt_wdata,
  input  wire psia_pkg::psia_word_t mgmt_rdata,
  input  wire logic                 mgmt_rvalid
);
  import psia_pkg::*;

  // Idle bus at time zero
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // Write pulse; released lines flip so no stale value is mistaken
  task automatic wr(input logic [4:0] a, input psia_word_t d);
    @(negedge ref_clk);
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    @(negedge ref_clk);
    mgmt_wr    = 1'b0;
    mgmt_addr  = ~a;
    mgmt_wdata = ~d;
  endtask

  // Read pulse; the answer is awaited for a few cycles only
  task automatic rd(input logic [4:0] a, output psia_word_t d);
    int k;
    @(negedge ref_clk);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(negedge ref_clk);
    mgmt_rd   = 1'b0;
    mgmt_addr = ~a;
    d         = 'x;
    for (k = 0; k < 4 && mgmt_rvalid !== 1'b1; k++) begin
      @(negedge ref_clk);
    end
    if (mgmt_rvalid === 1'b1) begin
      d = mgmt_rdata;
    end
  endtask
endmodule

// File: dv/psia_regs_bench.sv
`timescale 1ns/1ps
`include "psia_defs.svh"

// ============================================================
// Register slice bench
module psia_regs_bench;
  import psia_pkg::*;
  localparam logic [4:0] STS = `PSIA_OFS_LINK_STS;
  localparam logic [4:0] CTL = `PSIA_OFS_IND_CTRL;
  localparam logic [4:0] DAT = `PSIA_OFS_IND_DATA;
  localparam logic [4:0] ABL = `PSIA_OFS_ABILITY;

  logic       ref_clk;
  logic       resetn;
  logic [4:0] mgmt_addr;
  logic       mgmt_wr;
  logic       mgmt_rd;
  psia_word_t mgmt_wdata;
  psia_word_t mgmt_rdata;
  logic       mgmt_rvalid;
  logic       ms_fault_evt;
  logic       ms_resolved_master;
  logic       local_rx_ok;
  logic       remote_rx_ok;
  logic       lp_1000_fd;
  logic       lp_1000_hd;
  logic       idle_err_evt;
  int         n_mismatch;
  int         checks;
  int         cycles;
  int         i;

  psia_regs #(.EXT_AW(8)) psia_regs_i (
    .ref_clk(ref_clk), .resetn(resetn), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .ms_fault_evt(ms_fault_evt), .ms_resolved_master(ms_resolved_master),
    .local_rx_ok(local_rx_ok), .remote_rx_ok(remote_rx_ok),
    .lp_1000_fd(lp_1000_fd), .lp_1000_hd(lp_1000_hd),
    .idle_err_evt(idle_err_evt)
  );

  psia_station psia_station_i (
    .ref_clk(ref_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid)
  );

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  // ============================================================
  // Access helpers
  task automatic wr(input logic [4:0] a, input psia_word_t d);
    psia_station_i.wr(a, d);
  endtask

  task automatic chk(input string what, input logic [4:0] a,
                     input psia_word_t exp);
    psia_word_t got;
    psia_station_i.rd(a, got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Holds an event input high for n consecutive cycles
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      s = 1'b1;
    end
    @(negedge ref_clk);
    s = 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Test sequence
  initial begin
    ref_clk = 1'b0;
    resetn  = 1'b0;
    {ms_fault_evt, idle_err_evt} = 2'h0;
    {ms_resolved_master, local_rx_ok, remote_rx_ok} = 3'h0;
    {lp_1000_fd, lp_1000_hd} = 2'h0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk("sts", STS, 16'h0000);
    chk("abl", ABL, 16'h3000);
    chk("ctl", CTL, 16'h0000);
    chk("unmapped", 5'h03, 16'h0000);
    // Each level input walks through its own status bit
    for (i = 0; i < 5; i++) begin
      {ms_resolved_master, local_rx_ok, remote_rx_ok,
       lp_1000_fd, lp_1000_hd} = 5'h10 >> i;
      wr(STS, 16'hffff);
      chk("sts lvl", STS, 16'h4000 >> i);
    end
    {ms_resolved_master, local_rx_ok, remote_rx_ok} = 3'h0;
    {lp_1000_fd, lp_1000_hd} = 2'h0;
    // Latched fault and clear-on-read count
    pulse(ms_fault_evt, 1);
    chk("sts flt", STS, 16'h8000);
    chk("sts flt", STS, 16'h0000);
    pulse(idle_err_evt, 5);
    chk("sts cnt", STS, 16'h0005);
    chk("sts cnt", STS, 16'h0000);
    pulse(idle_err_evt, 300);
    chk("sts sat", STS, 16'h00ff);
    // Event and clearing read on one edge: the event survives the read
    fork
      chk("sts win", STS, 16'h0000);
      pulse(ms_fault_evt, 1);
      pulse(idle_err_evt, 1);
    join
    chk("sts win", STS, 16'h8001);
    // Reserved fields
    wr(CTL, 16'hffff);
    chk("ctl", CTL, 16'hc01f);
    wr(ABL, 16'hffff);
    chk("abl", ABL, 16'h3000);
    // Foreign device select is ignored
    wr(CTL, 16'h0000);
    wr(DAT, 16'h0010);
    wr(CTL, 16'h001f);
    chk("ptr", DAT, 16'h0000);
    wr(DAT, 16'h0010);
    chk("ptr", DAT, 16'h0010);
    wr(CTL, 16'h001e);
    chk("dat sel", DAT, 16'h0000);
    // Increment on write in the read-and-write mode (function 10)
    wr(CTL, 16'h801f);
    for (i = 0; i < 3; i++) begin
      wr(DAT, 16'h00a0 + 16'(i));
    end
    wr(CTL, 16'h001f);
    chk("ptr", DAT, 16'h0013);
    // No increment, then increment on read in function 10
    wr(DAT, 16'h0010);
    wr(CTL, 16'h401f);
    chk("dat", DAT, 16'h00a0);
    wr(DAT, 16'h00c5);
    chk("dat", DAT, 16'h00c5);
    wr(CTL, 16'h001f);
    chk("ptr", DAT, 16'h0010);
    wr(CTL, 16'h801f);
    chk("dat", DAT, 16'h00c5);
    chk("dat", DAT, 16'h00a1);
    chk("dat", DAT, 16'h00a2);
    wr(CTL, 16'h001f);
    chk("ptr", DAT, 16'h0013);
    // Increment on write only
    wr(DAT, 16'h0010);
    wr(CTL, 16'hc01f);
    chk("dat", DAT, 16'h00c5);
    chk("dat", DAT, 16'h00c5);
    wr(DAT, 16'h00b0);
    chk("dat", DAT, 16'h00a1);
    wr(CTL, 16'h001f);
    chk("ptr", DAT, 16'h0011);
    results();
  end
endmodule
